// file: src/dual_motor_pwm_drive.sv
// How it works
// - signed control per channel, minus one to one
// - minus one, zero, plus one: reverse, none, full
// - each channel outputs pwm and direction
// - overheat with shutdown enabled suppresses pwm
// - per-channel overheat shutdown enable bit
// - readable overheat status bit per channel
// - divider setting 0 to 63, zero fastest
// - frequency is 40 MHz over 1023 over divider+1
// - first divider azimuth, second pitch
// - clear flag one holds counter at zero
// - clear flag zero lets counter count
// - first clear flag azimuth, second pitch
// - clear flags readable and writable
// - controls, dividers, enables read back
// - position counters signed 16-bit, clear gives zero
// - brake signal generated per channel
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "motor_drive_defines.svh"

module dual_motor_pwm_drive
  import motor_drive_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic tick_40m_i,
  input wire logic [1:0] overheat_i,
  input motor_drive_pkg::encoder_in_s az_enc_i,
  input motor_drive_pkg::encoder_in_s pt_enc_i,
  output motor_drive_pkg::drive_out_s az_drive_o,
  output motor_drive_pkg::drive_out_s pt_drive_o
);
  import motor_drive_pkg::*;

  signed_control_s azimuth_signed_control;
  signed_control_s pitch_signed_control;
  signed_control_s next_azimuth_signed_control;
  signed_control_s next_pitch_signed_control;
  logic [5:0] modulation_rate_divider [2];
  logic [5:0] next_modulation_rate_divider [2];
  logic [1:0] overheat_shutdown_enable;
  logic [1:0] next_overheat_shutdown_enable;
  logic [1:0] position_counter_clear;
  logic [1:0] next_position_counter_clear;
  logic [1:0] brake_request;
  logic [1:0] next_brake_request;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [15:0] position [2];
  logic [1:0] pwm_raw;
  logic [1:0] pwm_q;
  logic [1:0] next_pwm_q;
  logic [1:0] dir_q;
  logic [1:0] next_dir_q;
  logic [1:0] brake_q;
  logic [1:0] next_brake_q;
  signed_control_s ctrl [2];
  encoder_in_s enc [2];

  function automatic logic [31:0] ctrl_word(input signed_control_s c);
    ctrl_word = {21'h0, c};
  endfunction

  assign ctrl[0] = azimuth_signed_control;
  assign ctrl[1] = pitch_signed_control;
  assign enc[0] = az_enc_i;
  assign enc[1] = pt_enc_i;

  // register file: writes
  always_comb begin
    next_azimuth_signed_control = azimuth_signed_control;
    next_pitch_signed_control = pitch_signed_control;
    next_modulation_rate_divider = modulation_rate_divider;
    next_overheat_shutdown_enable = overheat_shutdown_enable;
    next_position_counter_clear = position_counter_clear;
    next_brake_request = brake_request;
    if (wr_i) begin
      unique case (addr_i)
        // sign bit 1 is the -1 direction, magnitude 3ff is full duty
        `REG_AZ_CONTROL: next_azimuth_signed_control = wdata_i[`CTRL_SIGN_BIT:0];
        `REG_PT_CONTROL: next_pitch_signed_control = wdata_i[`CTRL_SIGN_BIT:0];
        `REG_RATE_DIV: begin
          next_modulation_rate_divider[0] = wdata_i[`DIV_W-1:0];
          next_modulation_rate_divider[1] = wdata_i[`PT_DIV_LSB+`DIV_W-1:`PT_DIV_LSB];
        end
        `REG_SHUTDOWN_EN: next_overheat_shutdown_enable = wdata_i[1:0];
        `REG_POS_CLEAR: next_position_counter_clear = wdata_i[1:0];
        `REG_BRAKE: next_brake_request = wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // register file: reads, data valid the cycle after rd_i
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        `REG_AZ_CONTROL: next_rdata = ctrl_word(azimuth_signed_control);
        `REG_PT_CONTROL: next_rdata = ctrl_word(pitch_signed_control);
        `REG_RATE_DIV: next_rdata = {18'h0, modulation_rate_divider[1], 2'h0,
                                     modulation_rate_divider[0]};
        `REG_SHUTDOWN_EN: next_rdata = {30'h0, overheat_shutdown_enable};
        `REG_OVERHEAT: next_rdata = {30'h0, overheat_i};
        `REG_POS_CLEAR: next_rdata = {30'h0, position_counter_clear};
        `REG_AZ_POSITION: next_rdata = {{16{position[0][15]}}, position[0]};
        `REG_PT_POSITION: next_rdata = {{16{position[1][15]}}, position[1]};
        `REG_BRAKE: next_rdata = {30'h0, brake_request};
        `REG_ID: next_rdata = `ID_VALUE;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      azimuth_signed_control <= '0;
      pitch_signed_control <= '0;
      modulation_rate_divider[0] <= `RATE_DIV_RESET;
      modulation_rate_divider[1] <= `RATE_DIV_RESET;
      overheat_shutdown_enable <= {2{`SHUTDOWN_EN_RESET}};
      position_counter_clear <= 2'b00;
      brake_request <= 2'b00;
      rdata <= 32'h0000_0000;
    end else begin
      azimuth_signed_control <= next_azimuth_signed_control;
      pitch_signed_control <= next_pitch_signed_control;
      modulation_rate_divider <= next_modulation_rate_divider;
      overheat_shutdown_enable <= next_overheat_shutdown_enable;
      position_counter_clear <= next_position_counter_clear;
      brake_request <= next_brake_request;
      rdata <= next_rdata;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      pwm_channel u_pwm (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick_40m_i),
        .rate_div_i(modulation_rate_divider[ch]),
        .magnitude_i(ctrl[ch].magnitude),
        .pwm_o(pwm_raw[ch])
      );
      position_counter u_pos (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .clear_i(position_counter_clear[ch]),
        .enc_i(enc[ch]),
        .count_o(position[ch])
      );
    end
  endgenerate

  // output stage, one flop so outputs are registered
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // overheat with shutdown enabled blocks excitation
      next_pwm_q[i] = pwm_raw[i] & ~(overheat_shutdown_enable[i] & overheat_i[i]);
      next_dir_q[i] = ctrl[i].sign;
      // brake when commanded or when the channel is shut down hot
      next_brake_q[i] = brake_request[i] | (overheat_shutdown_enable[i] & overheat_i[i]);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_q <= 2'b00;
      dir_q <= 2'b00;
      brake_q <= 2'b00;
    end else begin
      pwm_q <= next_pwm_q;
      dir_q <= next_dir_q;
      brake_q <= next_brake_q;
    end
  end

  assign rdata_o = rdata;
  assign az_drive_o = '{pwm: pwm_q[0], direction: dir_q[0], brake: brake_q[0]};
  assign pt_drive_o = '{pwm: pwm_q[1], direction: dir_q[1], brake: brake_q[1]};
endmodule

// file: src/motor_drive_defines.svh
`ifndef MOTOR_DRIVE_DEFINES_SVH
`define MOTOR_DRIVE_DEFINES_SVH

`define ADDR_W 4
`define DATA_W 32
`define REG_AZ_CONTROL 4'h0
`define REG_PT_CONTROL 4'h1
`define REG_RATE_DIV 4'h2
`define REG_SHUTDOWN_EN 4'h3
`define REG_OVERHEAT 4'h4
`define REG_POS_CLEAR 4'h5
`define REG_AZ_POSITION 4'h6
`define REG_PT_POSITION 4'h7
`define REG_BRAKE 4'h8
`define REG_ID 4'h9
`define ID_VALUE 32'h0000_5a01
`define DUTY_W 10
`define DUTY_MAX 10'h3ff
`define PERIOD_LAST 10'h3fe
`define DIV_W 6
`define POS_W 16
`define POS_ZERO 16'h0000
`define PT_DIV_LSB 8
`define CTRL_SIGN_BIT 10
`define RATE_DIV_RESET 6'h01
`define SHUTDOWN_EN_RESET 1'b1

`endif

// file: src/motor_drive_pkg.sv
package motor_drive_pkg;
  typedef struct packed {
    logic sign;
    logic [9:0] magnitude;
  } signed_control_s;

  typedef struct packed {
    logic pwm;
    logic direction;
    logic brake;
  } drive_out_s;

  typedef struct packed {
    logic step;
    logic up;
  } encoder_in_s;
endpackage

// file: src/position_counter.sv
`timescale 1ns/1ps
`include "motor_drive_defines.svh"

module position_counter
  import motor_drive_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic clear_i,
  input motor_drive_pkg::encoder_in_s enc_i,
  output logic [15:0] count_o
);
  logic [15:0] count;
  logic [15:0] next_count;

  always_comb begin
    next_count = count;
    if (clear_i) begin
      next_count = `POS_ZERO;
    end else if (enc_i.step) begin
      // wraps as 16-bit two's complement
      next_count = enc_i.up ? count + 16'h0001 : count - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= `POS_ZERO;
    end else begin
      count <= next_count;
    end
  end

  assign count_o = count;
endmodule

// file: src/pwm_channel.sv
`timescale 1ns/1ps
`include "motor_drive_defines.svh"

module pwm_channel
  import motor_drive_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic tick_i,
  input wire logic [5:0] rate_div_i,
  input wire logic [9:0] magnitude_i,
  output logic pwm_o
);
  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic [9:0] period_cnt;
  logic [9:0] next_period_cnt;
  logic pwm;
  logic next_pwm;

  always_comb begin
    next_div_cnt = div_cnt;
    next_period_cnt = period_cnt;
    if (tick_i) begin
      // divider enables the period counter once per rate_div+1 ticks
      if (div_cnt >= rate_div_i) begin
        next_div_cnt = '0;
        // 1023 counts per period, 0..1022
        if (period_cnt >= `PERIOD_LAST) begin
          next_period_cnt = '0;
        end else begin
          next_period_cnt = period_cnt + 10'h001;
        end
      end else begin
        next_div_cnt = div_cnt + 6'h01;
      end
    end
    next_pwm = (period_cnt < magnitude_i);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= '0;
      period_cnt <= '0;
      pwm <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      period_cnt <= next_period_cnt;
      pwm <= next_pwm;
    end
  end

  assign pwm_o = pwm;
endmodule

// file: verification/amp_model.sv
`timescale 1ns/1ps
module amp_model
  import motor_drive_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [1:0] hot_i,
  output logic [1:0] overheat_o,
  output motor_drive_pkg::encoder_in_s az_enc_o,
  output motor_drive_pkg::encoder_in_s pt_enc_o
);
  assign overheat_o = hot_i;
  initial begin
    az_enc_o = '0;
    pt_enc_o = '0;
  end
  // up flips between steps so a counter that ignores step is caught
  task automatic turn(input bit ch, input int n, input bit up);
    repeat (n) begin
      @(posedge clk_sys_i);
      if (ch) pt_enc_o <= '{1'b1, up};
      else az_enc_o <= '{1'b1, up};
      @(posedge clk_sys_i);
      if (ch) pt_enc_o <= '{1'b0, !up};
      else az_enc_o <= '{1'b0, !up};
    end
  endtask
endmodule

// file: verification/motor_drive_checker.sv
`timescale 1ns/1ps
module motor_drive_checker
  import motor_drive_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] overheat_i,
  input motor_drive_pkg::drive_out_s az_drive_o,
  input motor_drive_pkg::drive_out_s pt_drive_o
);
  logic [9:0] az_mag, next_az_mag;
  logic [1:0] en, next_en;
  always_comb begin
    next_az_mag = az_mag;
    next_en = en;
    if (wr_i && addr_i == 4'h0) next_az_mag = wdata_i[9:0];
    if (wr_i && addr_i == 4'h3) next_en = wdata_i[1:0];
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      az_mag <= 10'h000;
      en <= 2'h3;
    end else begin
      az_mag <= next_az_mag;
      en <= next_en;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("read data not zero");
  a_status_read: assert property (rd_i && addr_i == 4'h4 |=> rdata_o == {30'h0, $past(overheat_i)})
    else $error("overheat status wrong");
  a_az_dir: assert property (wr_i && addr_i == 4'h0 |-> ##2 az_drive_o.direction == $past(wdata_i[10], 2))
    else $error("azimuth direction wrong");
  a_pt_dir: assert property (wr_i && addr_i == 4'h1 |-> ##2 pt_drive_o.direction == $past(wdata_i[10], 2))
    else $error("pitch direction wrong");
  a_az_off: assert property ((az_mag == 10'h000)[*4] |-> !az_drive_o.pwm) else $error("pwm on at zero");
  a_az_full: assert property ((az_mag == 10'h3ff && !(en[0] && overheat_i[0]))[*4] |-> az_drive_o.pwm)
    else $error("pwm off at full");
  a_az_hot: assert property ((en[0] && overheat_i[0])[*3] |-> !az_drive_o.pwm) else $error("azimuth hot");
  a_pt_hot: assert property ((en[1] && overheat_i[1])[*3] |-> !pt_drive_o.pwm) else $error("pitch hot");
endmodule
bind dual_motor_pwm_drive motor_drive_checker i_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .overheat_i(overheat_i), .az_drive_o(az_drive_o), .pt_drive_o(pt_drive_o));

// file: verification/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  import motor_drive_pkg::*;
  logic clk_sys_i, arst_n_i, wr_i, rd_i, tick_40m_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [1:0] overheat_i, hot, pw;
  encoder_in_s az_enc_i, pt_enc_i;
  drive_out_s az_drive_o, pt_drive_o;
  int fails = 0;
  int num_checks = 0;
  int n;
  assign pw = {pt_drive_o.pwm, az_drive_o.pwm};
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  dual_motor_pwm_drive i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tick_40m_i(tick_40m_i), .overheat_i(overheat_i),
    .az_enc_i(az_enc_i), .pt_enc_i(pt_enc_i), .az_drive_o(az_drive_o), .pt_drive_o(pt_drive_o));
  amp_model i_amp (.clk_sys_i(clk_sys_i), .hot_i(hot), .overheat_o(overheat_i), .az_enc_o(az_enc_i),
    .pt_enc_o(pt_enc_i));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 `CHK("rdata", e, rdata_o)
  endtask
  // rise to rise of one pwm, counted in clocks with a tick every clock
  task automatic period(input bit ch, input int e);
    n = 0;
    repeat (3000) begin @(posedge clk_sys_i); if (!pw[ch]) break; end
    repeat (3000) begin @(posedge clk_sys_i); if (pw[ch]) break; end
    while (pw[ch] && n < 9000) begin @(posedge clk_sys_i); n++; end
    while (!pw[ch] && n < 9000) begin @(posedge clk_sys_i); n++; end
    `CHK("period", e, n)
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    stop_test;
  end
  initial begin
    {arst_n_i, wr_i, rd_i, addr_i, wdata_i, hot} = '0;
    tick_40m_i = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(4'h2, 32'h101);
    rd(4'h3, 32'h3);
    rd(4'h5, 32'h0);
    rd(4'hf, 32'h0);
    rd(4'h9, 32'h5a01);
    $display("test reset done");
    wr(4'h0, 32'h7ff);
    wr(4'h1, 32'h155);
    rd(4'h0, 32'h7ff);
    rd(4'h1, 32'h155);
    `CHK("direction", 2'b01, {pt_drive_o.direction, az_drive_o.direction})
    wr(4'h2, 32'h3f00);
    rd(4'h2, 32'h3f00);
    $display("test control done");
    wr(4'h0, 32'h200);
    wr(4'h1, 32'h200);
    wr(4'h2, 32'h100);
    period(1'b0, 1023);
    period(1'b1, 2046);
    $display("test rate done");
    wr(4'h0, 32'h3ff);
    wr(4'h1, 32'h3ff);
    hot <= 2'b11;
    rd(4'h4, 32'h3);
    repeat (4) @(posedge clk_sys_i);
    `CHK("hot pwm", 2'b00, pw)
    `CHK("hot brake", 2'b11, {pt_drive_o.brake, az_drive_o.brake})
    wr(4'h3, 32'h2);
    repeat (4) @(posedge clk_sys_i);
    `CHK("enable pwm", 2'b01, pw)
    `CHK("enable brake", 2'b10, {pt_drive_o.brake, az_drive_o.brake})
    hot <= 2'b00;
    wr(4'h0, 32'h0);
    wr(4'h1, 32'h0);
    repeat (4) @(posedge clk_sys_i);
    `CHK("stop pwm", 2'b00, pw)
    `CHK("cool brake", 2'b00, {pt_drive_o.brake, az_drive_o.brake})
    wr(4'h8, 32'h1);
    rd(4'h8, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    `CHK("req brake", 2'b01, {pt_drive_o.brake, az_drive_o.brake})
    $display("test overheat done");
    wr(4'h5, 32'h3);
    i_amp.turn(1'b0, 3, 1'b1);
    rd(4'h6, 32'h0);
    wr(4'h5, 32'h0);
    i_amp.turn(1'b0, 3, 1'b1);
    i_amp.turn(1'b0, 5, 1'b0);
    i_amp.turn(1'b1, 4, 1'b1);
    rd(4'h6, 32'hffff_fffe);
    rd(4'h7, 32'h4);
    wr(4'h5, 32'h1);
    rd(4'h5, 32'h1);
    rd(4'h6, 32'h0);
    rd(4'h7, 32'h4);
    $display("test position done");
    stop_test;
  end
endmodule
